// ===== rtl/rlc_regs.svh
// Contract
// - Sync word is 64 bits in two registers, low word first, LSB lowest lane.
// - Writing the length header field sets payload bytes to transmit.
// - Reading the length header field returns the last received frame length.
// - Transmit and receive FIFOs each hold 64 bytes.
// - Frames up to 255 bytes pass by refilling or draining the FIFO.
// - Margin codes 0..3 give TX thresholds 8,12,16,32 and RX 56,52,48,32.
// - On-air rate equals master rate clock divided by divider plus one.
// - Pin one codes 0,1,2 give interrupt, wait-done and wake-on-receive.
// - Code 3 gives access code end in transmit, frame sync in receive.
// - Code 4 gives modulation enable in transmit, carrier detect in receive.
// - Code 5 preamble detect; codes 6 and 7 direct receive and transmit data.
// - Pin one codes 8..15 give power-downs, switch, tune, demod, flags, FIFO, enable.
// - Pin two shares the map except wake-up, tune bit 1 and IQ demod.
// - End flags selection presents operation, calibration, converter and gain-done.
// - Pin one invert bit inverts its selected signal when set.
// - Pin two invert bit inverts its selected signal when set.
// - Clock pin codes 0..3 give interrupt flag, low battery, crystal ready, SPI data.
// - Clock pin codes 4..6 give baseband clock, 320 us tick, oscillator.
// - Clock pin code 7 gives the data clock.
// - Clock pin invert bit inverts its selected signal when set.
// - Interrupt flag on the clock pin follows the active source's status flag.
`ifndef RLC_REGS_SVH
`define RLC_REGS_SVH
`define RLC_ADDR_SYNC_LO  32'h50001014
`define RLC_ADDR_SYNC_HI  32'h50001018
`define RLC_ADDR_FIFO     32'h50001020
`define RLC_ADDR_RATE     32'h50001024
`define RLC_ADDR_PINS     32'h50001028
`define RLC_RST_WORD      32'h00000000
`define RLC_RST_BYTE      8'h00
`define RLC_LEN_LSB       0
`define RLC_FPM_LSB       30
`define RLC_SEL1_LSB      0
`define RLC_INV1_BIT      6
`define RLC_SEL2_LSB      8
`define RLC_INV2_BIT      14
`define RLC_CKS_LSB       16
`define RLC_CKI_BIT       22
`define RLC_DEPTH         7'h40
`define RLC_TX_THR0       7'h08
`define RLC_TX_THR1       7'h0C
`define RLC_TX_THR2       7'h10
`define RLC_TX_THR3       7'h20
`define RLC_RX_THR0       7'h38
`define RLC_RX_THR1       7'h34
`define RLC_RX_THR2       7'h30
`define RLC_RX_THR3       7'h20
`define RLC_CLK_NS        100
`define RLC_RC_TICK_NS    320000
`define RLC_RC_TICK_CYC   ((`RLC_RC_TICK_NS + `RLC_CLK_NS - 1) / `RLC_CLK_NS)
`endif

// ===== rtl/rlc_pkg.sv
package rlc_pkg;
   typedef logic [7:0] rlc_byte_type;
   typedef enum logic [2:0] {
      RLC_CK_RF_INTERRUPT_FLAG = 3'h0,
      RLC_CK_BATT = 3'h1,
      RLC_CK_CRYSTAL_READY = 3'h2,
      RLC_CK_SDO  = 3'h3,
      RLC_CK_BASEBAND_CLOCK = 3'h4,
      RLC_CK_TICK = 3'h5,
      RLC_CK_RCO  = 3'h6,
      RLC_CK_DCLK = 3'h7
   } rlc_ck_sel_type;
endpackage : rlc_pkg

// ===== rtl/rlc_byte_ram.sv
`timescale 1ns/10ps
module rlc_byte_ram
   import rlc_pkg::*;
(
   input  wire logic         clock,
   input  wire logic         wr_en,
   input  wire logic [5:0]   wr_addr,
   input  rlc_byte_type      wr_data,
   input  wire logic         rd_en,
   input  wire logic [5:0]   rd_addr,
   output rlc_byte_type      rd_data_q
);
   rlc_byte_type mem_q [0:63];

   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
      if (rd_en) begin
         rd_data_q <= mem_q[rd_addr];
      end
   end
endmodule : rlc_byte_ram

// ===== rtl/rlc_top.sv
`timescale 1ns/10ps
`include "rlc_regs.svh"
module rlc_top
   import rlc_pkg::*;
(
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [31:0]  paddr,
   input  wire logic [31:0]  pwdata,
   input  wire logic [3:0]   pstrb,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   output logic [63:0]       packet_sync_word,
   output rlc_byte_type      tx_frame_length,
   input  wire logic         tx_push,
   input  rlc_byte_type      tx_push_data,
   output logic [6:0]        tx_level,
   input  wire logic         tx_frame_start,
   input  wire logic         tx_pop,
   output rlc_byte_type      tx_pop_data,
   output logic [7:0]        tx_remaining,
   input  wire logic         rx_push,
   input  rlc_byte_type      rx_push_data,
   input  wire logic         rx_frame_end,
   input  wire logic         rx_pop,
   output rlc_byte_type      rx_pop_data,
   output logic [6:0]        rx_level,
   output logic              fifo_pointer_flag,
   input  wire logic         master_rate_clock,
   output logic              data_rate_tick,
   input  wire logic         radio_tx_mode,
   input  wire logic         rf_interrupt,
   input  wire logic         rf_interrupt_flag,
   input  wire logic         wait_tx_rx_done,
   input  wire logic         wake_on_rx,
   input  wire logic         wake_up,
   input  wire logic         access_code_end,
   input  wire logic         frame_sync_out,
   input  wire logic         tx_mod_enable,
   input  wire logic         carrier_detect,
   input  wire logic         preamble_detect_out,
   input  wire logic         rx_direct_data,
   input  wire logic         tx_direct_data,
   input  wire logic         receive_power_down,
   input  wire logic         transmit_power_down,
   input  wire logic         power_amp_switch,
   input  wire logic [1:0]   vco_tune_bit,
   input  wire logic         demod_i_out,
   input  wire logic         demod_iq_out,
   input  wire logic [3:0]   internal_end_flags,
   input  wire logic         clock_enable,
   input  wire logic         spi_data_out,
   input  wire logic         baseband_clock,
   input  wire logic         low_battery_flag,
   input  wire logic         crystal_ready,
   input  wire logic         rc_osc,
   output logic              general_pin_one,
   output logic              general_pin_two,
   output logic              clock_out_pin
);
   ////////////////////////////////////////////////////////////////////////////
   logic [31:0]    sync_lo_q;
   logic [31:0]    sync_hi_q;
   rlc_byte_type   len_tx_q;
   rlc_byte_type   len_rx_q;
   logic [1:0]     fpm_q;
   rlc_byte_type   rate_div_q;
   logic [3:0]     sel1_q;
   logic [3:0]     sel2_q;
   rlc_ck_sel_type cks_q;
   logic           inv1_q;
   logic           inv2_q;
   logic           cki_q;
   logic           pready_q;
   logic           pslverr_q;
   logic [31:0]    prdata_q;
   logic [31:0]    wmask;
   logic           acc;
   logic           hit;
   logic           wr_en;
   logic           sel_lo;
   logic           sel_hi;
   logic           sel_fifo;
   logic           sel_rate;
   logic           sel_pins;
   logic [31:0]    rd_data;
   logic [31:0]    fifo_wr;
   logic [31:0]    pins_wr;

   function automatic logic [31:0] rlc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [31:0] m);
      return (old_v & ~m) | (new_v & m);
   endfunction : rlc_merge

   genvar gi;
   for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{pstrb[gi]}};
   end

   // The slave answers in the second access cycle so read data come from a register.
   assign acc      = psel & penable & ~pready_q;
   assign wr_en    = psel & penable & pready_q & pwrite & ~pslverr_q;
   assign sel_lo   = (paddr == `RLC_ADDR_SYNC_LO);
   assign sel_hi   = (paddr == `RLC_ADDR_SYNC_HI);
   assign sel_fifo = (paddr == `RLC_ADDR_FIFO);
   assign sel_rate = (paddr == `RLC_ADDR_RATE);
   assign sel_pins = (paddr == `RLC_ADDR_PINS);
   assign hit      = sel_lo | sel_hi | sel_fifo | sel_rate | sel_pins;
   assign fifo_wr  = rlc_merge({fpm_q, 22'h000000, len_tx_q}, pwdata, wmask);
   assign pins_wr  = rlc_merge({9'h000, cki_q, 3'h0, cks_q, 1'h0, inv2_q, 2'h0, sel2_q,
                                1'h0, inv1_q, 2'h0, sel1_q}, pwdata, wmask);

   assign rd_data  = sel_lo   ? sync_lo_q :
                     sel_hi   ? sync_hi_q :
                     sel_fifo ? {fpm_q, 22'h000000, len_rx_q} :
                     sel_rate ? {24'h000000, rate_div_q} :
                     sel_pins ? {29'h00000000, general_pin_two, general_pin_one,
                                 clock_out_pin} :
                     `RLC_RST_WORD;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= `RLC_RST_WORD;
      end else begin
         pready_q  <= acc;
         pslverr_q <= acc & ~hit;
         if (acc) begin
            prdata_q <= pwrite ? `RLC_RST_WORD : rd_data;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync_lo_q  <= `RLC_RST_WORD;
         sync_hi_q  <= `RLC_RST_WORD;
         len_tx_q   <= `RLC_RST_BYTE;
         fpm_q      <= 2'h0;
         rate_div_q <= `RLC_RST_BYTE;
      end else if (wr_en) begin
         if (sel_lo) begin
            sync_lo_q <= rlc_merge(sync_lo_q, pwdata, wmask);
         end
         if (sel_hi) begin
            sync_hi_q <= rlc_merge(sync_hi_q, pwdata, wmask);
         end
         if (sel_fifo) begin
            len_tx_q <= fifo_wr[`RLC_LEN_LSB +: 8];
            fpm_q    <= fifo_wr[`RLC_FPM_LSB +: 2];
         end
         if (sel_rate) begin
            rate_div_q <= 8'(rlc_merge({24'h000000, rate_div_q}, pwdata, wmask));
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sel1_q <= 4'h0;
         sel2_q <= 4'h0;
         cks_q  <= RLC_CK_RF_INTERRUPT_FLAG;
         inv1_q <= 1'b0;
         inv2_q <= 1'b0;
         cki_q  <= 1'b0;
      end else if (wr_en & sel_pins) begin
         sel1_q <= pins_wr[`RLC_SEL1_LSB +: 4];
         inv1_q <= pins_wr[`RLC_INV1_BIT];
         sel2_q <= pins_wr[`RLC_SEL2_LSB +: 4];
         inv2_q <= pins_wr[`RLC_INV2_BIT];
         cks_q  <= rlc_ck_sel_type'(pins_wr[`RLC_CKS_LSB +: 3]);
         cki_q  <= pins_wr[`RLC_CKI_BIT];
      end
   end

   assign prdata           = prdata_q;
   assign pready           = pready_q;
   assign pslverr          = pslverr_q;
   assign packet_sync_word = {sync_hi_q, sync_lo_q};
   assign tx_frame_length  = len_tx_q;

   ////////////////////////////////////////////////////////////////////////////
   // Only 64 bytes are stored; longer frames rely on the far side refilling or
   // draining while the frame runs, the remaining count tracks up to 255.
   logic [5:0]   tx_wptr_q;
   logic [5:0]   tx_rptr_q;
   logic [6:0]   tx_level_q;
   logic [7:0]   tx_rem_q;
   logic [5:0]   rx_wptr_q;
   logic [5:0]   rx_rptr_q;
   logic [6:0]   rx_level_q;
   rlc_byte_type rx_cnt_q;
   rlc_byte_type len_rx_d;
   logic         tx_wr;
   logic         tx_rd;
   logic         rx_wr;
   logic         rx_rd;
   logic [6:0]   tx_thr;
   logic [6:0]   rx_thr;
   logic         fpf_q;

   assign tx_wr  = tx_push & (tx_level_q != `RLC_DEPTH);
   assign tx_rd  = tx_pop & (tx_level_q != 7'h00) & (tx_rem_q != 8'h00);
   assign rx_wr  = rx_push & (rx_level_q != `RLC_DEPTH);
   assign rx_rd  = rx_pop & (rx_level_q != 7'h00);
   assign len_rx_d = rx_cnt_q + {7'h00, rx_wr};
   assign tx_thr = (fpm_q == 2'h0) ? `RLC_TX_THR0 : (fpm_q == 2'h1) ? `RLC_TX_THR1 :
                   (fpm_q == 2'h2) ? `RLC_TX_THR2 : `RLC_TX_THR3;
   assign rx_thr = (fpm_q == 2'h0) ? `RLC_RX_THR0 : (fpm_q == 2'h1) ? `RLC_RX_THR1 :
                   (fpm_q == 2'h2) ? `RLC_RX_THR2 : `RLC_RX_THR3;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tx_wptr_q  <= 6'h00;
         tx_rptr_q  <= 6'h00;
         tx_level_q <= 7'h00;
         tx_rem_q   <= `RLC_RST_BYTE;
      end else begin
         tx_wptr_q  <= tx_wptr_q + {5'h00, tx_wr};
         tx_rptr_q  <= tx_rptr_q + {5'h00, tx_rd};
         tx_level_q <= tx_level_q + {6'h00, tx_wr} - {6'h00, tx_rd};
         if (tx_frame_start) begin
            tx_rem_q <= len_tx_q;
         end else if (tx_rd) begin
            tx_rem_q <= tx_rem_q - 8'h01;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_wptr_q  <= 6'h00;
         rx_rptr_q  <= 6'h00;
         rx_level_q <= 7'h00;
         rx_cnt_q   <= `RLC_RST_BYTE;
         len_rx_q   <= `RLC_RST_BYTE;
         fpf_q      <= 1'b0;
      end else begin
         rx_wptr_q  <= rx_wptr_q + {5'h00, rx_wr};
         rx_rptr_q  <= rx_rptr_q + {5'h00, rx_rd};
         rx_level_q <= rx_level_q + {6'h00, rx_wr} - {6'h00, rx_rd};
         if (rx_frame_end) begin
            len_rx_q <= len_rx_d;
            rx_cnt_q <= `RLC_RST_BYTE;
         end else begin
            rx_cnt_q <= len_rx_d;
         end
         fpf_q <= radio_tx_mode ? (tx_level_q <= tx_thr) : (rx_level_q >= rx_thr);
      end
   end

   rlc_byte_ram u_tx_ram (
      .clock     (clock),
      .wr_en     (tx_wr),
      .wr_addr   (tx_wptr_q),
      .wr_data   (tx_push_data),
      .rd_en     (tx_rd),
      .rd_addr   (tx_rptr_q),
      .rd_data_q (tx_pop_data)
   );

   rlc_byte_ram u_rx_ram (
      .clock     (clock),
      .wr_en     (rx_wr),
      .wr_addr   (rx_wptr_q),
      .wr_data   (rx_push_data),
      .rd_en     (rx_rd),
      .rd_addr   (rx_rptr_q),
      .rd_data_q (rx_pop_data)
   );

   assign tx_level          = tx_level_q;
   assign tx_remaining      = tx_rem_q;
   assign rx_level          = rx_level_q;
   assign fifo_pointer_flag = fpf_q;

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0]  rate_cnt_q;
   logic        rate_tick_q;
   logic        dclk_q;
   logic [11:0] rc_cnt_q;
   logic        rc_tick_q;
   logic [2:0]  as_in;
   logic [2:0]  as_s1_q;
   logic [2:0]  as_s2_q;

   // The master rate clock is a one-cycle enable; counting it keeps one clock domain.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rate_cnt_q  <= `RLC_RST_BYTE;
         rate_tick_q <= 1'b0;
         dclk_q      <= 1'b0;
      end else begin
         rate_tick_q <= 1'b0;
         if (master_rate_clock) begin
            if (rate_cnt_q == rate_div_q) begin
               rate_cnt_q  <= `RLC_RST_BYTE;
               rate_tick_q <= 1'b1;
               dclk_q      <= ~dclk_q;
            end else begin
               rate_cnt_q <= rate_cnt_q + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rc_cnt_q  <= 12'h000;
         rc_tick_q <= 1'b0;
      end else begin
         rc_tick_q <= (rc_cnt_q == 12'(`RLC_RC_TICK_CYC - 1));
         if (rc_cnt_q == 12'(`RLC_RC_TICK_CYC - 1)) begin
            rc_cnt_q <= 12'h000;
         end else begin
            rc_cnt_q <= rc_cnt_q + 12'h001;
         end
      end
   end

   // Battery, crystal and oscillator levels come from analog blocks with no tie to this clock.
   assign as_in = {rc_osc, crystal_ready, low_battery_flag};
   for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            as_s1_q[gi] <= 1'b0;
            as_s2_q[gi] <= 1'b0;
         end else begin
            as_s1_q[gi] <= as_in[gi];
            as_s2_q[gi] <= as_s1_q[gi];
         end
      end
   end

   assign data_rate_tick = rate_tick_q;

   ////////////////////////////////////////////////////////////////////////////
   logic [15:0] src1;
   logic [15:0] src2;
   logic [7:0]  srck;
   logic        end_any;
   logic        pin1_q;
   logic        pin2_q;
   logic        ck_q;

   // End flags are merged onto one level; they are meant for bring-up only.
   assign end_any = |internal_end_flags;
   // Codes with no transmit entry carry the receive signal in either state.
   assign src1 = {clock_enable, fpf_q, end_any, demod_i_out, vco_tune_bit[0],
                  power_amp_switch, transmit_power_down, receive_power_down,
                  tx_direct_data, rx_direct_data, preamble_detect_out,
                  radio_tx_mode ? tx_mod_enable : carrier_detect,
                  radio_tx_mode ? access_code_end : frame_sync_out,
                  wake_on_rx, wait_tx_rx_done, rf_interrupt};
   assign src2 = {src1[15:13], demod_iq_out, vco_tune_bit[1], src1[10:3],
                  wake_up, src1[1:0]};
   assign srck = {dclk_q, as_s2_q[2], rc_tick_q, baseband_clock,
                  spi_data_out, as_s2_q[1], as_s2_q[0], rf_interrupt_flag};

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pin1_q <= 1'b0;
         pin2_q <= 1'b0;
         ck_q   <= 1'b0;
      end else begin
         pin1_q <= src1[sel1_q] ^ inv1_q;
         pin2_q <= src2[sel2_q] ^ inv2_q;
         ck_q   <= srck[cks_q] ^ cki_q;
      end
   end

   assign general_pin_one = pin1_q;
   assign general_pin_two = pin2_q;
   assign clock_out_pin   = ck_q;
endmodule : rlc_top

// ===== test/rlc_top_monitor.sv
`timescale 1ns/10ps
`include "rlc_regs.svh"
module rlc_top_monitor
   import rlc_pkg::*;
(
   input wire logic         clock,
   input wire logic         rst_n,
   input wire logic         psel,
   input wire logic         penable,
   input wire logic         pwrite,
   input wire logic [31:0]  paddr,
   input wire logic [31:0]  pwdata,
   input wire logic [3:0]   pstrb,
   input wire logic         pready,
   input wire logic         pslverr,
   input wire logic [63:0]  packet_sync_word,
   input wire rlc_byte_type tx_frame_length,
   input wire logic         tx_frame_start,
   input wire logic         tx_pop,
   input wire logic [6:0]   tx_level,
   input wire logic [7:0]   tx_remaining,
   input wire logic         rx_push,
   input wire logic         rx_pop,
   input wire logic [6:0]   rx_level
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   wire wr_done = pready && !pslverr && pwrite && pstrb == 4'hF;
   wire mapped  = paddr == `RLC_ADDR_SYNC_LO || paddr == `RLC_ADDR_SYNC_HI || paddr == `RLC_ADDR_FIFO
                  || paddr == `RLC_ADDR_RATE || paddr == `RLC_ADDR_PINS;
   one_wait_a: assert property (psel && penable && !pready |=> pready) else $error("pready late");
   pready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
   setup_quiet_a: assert property (psel && !penable |-> !pready) else $error("pready in setup");
   err_decode_a: assert property (pready |-> pslverr == !mapped) else $error("bad pslverr");
   lo_write_a: assert property (wr_done && paddr == `RLC_ADDR_SYNC_LO
      |=> packet_sync_word[31:0] == $past(pwdata)) else $error("sync low wrong");
   hi_write_a: assert property (wr_done && paddr == `RLC_ADDR_SYNC_HI
      |=> packet_sync_word[63:32] == $past(pwdata)) else $error("sync high wrong");
   len_write_a: assert property (wr_done && paddr == `RLC_ADDR_FIFO
      |=> tx_frame_length == $past(pwdata[7:0])) else $error("length wrong");
   frame_load_a: assert property (tx_frame_start |=> tx_remaining == $past(tx_frame_length))
      else $error("remaining not loaded");
   pop_count_a: assert property (tx_pop && !tx_frame_start && tx_level != 0 && tx_remaining != 0
      |=> tx_remaining == $past(tx_remaining) - 8'h01) else $error("remaining wrong");
   depth_cap_a: assert property (rx_level <= `RLC_DEPTH && tx_level <= `RLC_DEPTH) else $error("over depth");
   rx_fill_a: assert property (rx_push && !rx_pop && rx_level < `RLC_DEPTH
      |=> rx_level == $past(rx_level) + 7'h01) else $error("rx level wrong");
   cover property (pslverr);
   cover property (rx_level == `RLC_DEPTH);
   cover property (tx_frame_start);
endmodule : rlc_top_monitor
bind rlc_top rlc_top_monitor i_rlc_top_monitor (.*);

// ===== test/rlc_radio_model.sv
`timescale 1ns/10ps
module rlc_radio_model
(
   input  wire logic        clock,
   input  wire logic [4:0]  pick,
   output logic [25:0]      src,
   output logic             master_rate_clock
);
   // One source at a time is raised so that a wrong route reads as a plain zero.
   initial begin
      src = 26'h0000000;
      master_rate_clock = 1'b0;
   end
   always @(posedge clock) begin
      src <= 26'h0000001 << pick;
      master_rate_clock <= !master_rate_clock;
   end
endmodule : rlc_radio_model

// ===== test/test_rlc_top.sv
`timescale 1ns/10ps
`include "rlc_regs.svh"
module test_rlc_top
   import rlc_pkg::*;
;
   logic         clock, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [31:0]  paddr, pwdata, prdata, r;
   logic [3:0]   pstrb;
   logic [63:0]  packet_sync_word;
   rlc_byte_type tx_frame_length, tx_push_data, tx_pop_data, rx_push_data, rx_pop_data;
   logic         tx_push, tx_frame_start, tx_pop, rx_push, rx_frame_end, rx_pop, radio_tx_mode, e;
   logic         data_rate_tick, fifo_pointer_flag, master_rate_clock;
   logic [6:0]   tx_level, rx_level;
   logic [7:0]   tx_remaining;
   logic         general_pin_one, general_pin_two, clock_out_pin;
   logic [4:0]   pick;
   logic [25:0]  src;
   wire          rf_interrupt, rf_interrupt_flag, wait_tx_rx_done, wake_on_rx, wake_up, access_code_end;
   wire          frame_sync_out, tx_mod_enable, carrier_detect, preamble_detect_out, rx_direct_data;
   wire          tx_direct_data, receive_power_down, transmit_power_down, power_amp_switch, demod_i_out;
   wire          demod_iq_out, clock_enable, spi_data_out, baseband_clock, low_battery_flag, crystal_ready, rc_osc;
   wire [1:0]    vco_tune_bit;
   wire [3:0]    internal_end_flags;
   int           fail_count, num_checks;
   localparam int one_map [16] = '{0, 1, 2, 5, 7, 8, 9, 10, 11, 12, 13, 14, 16, 18, 30, 19};
   localparam int ck_map [8] = '{25, 22, 23, 20, 21, 31, 24, 31};
   localparam logic [31:0] reg_list [5] = '{`RLC_ADDR_SYNC_LO, `RLC_ADDR_SYNC_HI, `RLC_ADDR_FIFO,
                                            `RLC_ADDR_RATE, `RLC_ADDR_PINS};
   assign {rf_interrupt_flag, rc_osc, crystal_ready, low_battery_flag, baseband_clock, spi_data_out, clock_enable,
           internal_end_flags[2], demod_iq_out, demod_i_out, vco_tune_bit, power_amp_switch, transmit_power_down,
           receive_power_down, tx_direct_data, rx_direct_data, preamble_detect_out, carrier_detect, tx_mod_enable,
           frame_sync_out, access_code_end, wake_up, wake_on_rx, wait_tx_rx_done, rf_interrupt} = src;
   assign {internal_end_flags[3], internal_end_flags[1:0]} = 3'h0;
   rlc_top i_rlc_top (.*);
   rlc_radio_model i_rlc_radio_model (.*);
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      if (fail_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cycles(input int n);
      repeat (n) @(posedge clock);
   endtask : cycles
   // The idle cycle after a transfer keeps one write per signal per step.
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 16);
      chk(64'(pready), 64'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hF);
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000, 4'h0);
      chk({r, 31'h0, e}, {exp, 32'h0});
   endtask : rd
   ////////////////////////////////////////////////////////////////
   task automatic reset_values;
      for (int i = 0; i < 5; i++) rd(reg_list[i], `RLC_RST_WORD);
      apb(1'b0, 32'h5000101C, 32'h00000000, 4'h0);
      chk({r, 31'h0, e}, {32'h0, 32'h1});
      apb(1'b1, 32'h50001015, 32'hFFFFFFFF, 4'hF);
      chk(64'(e), 64'h1);
      rd(`RLC_ADDR_SYNC_LO, `RLC_RST_WORD);
   endtask : reset_values
   task automatic sync_word;
      wr(`RLC_ADDR_SYNC_LO, 32'h89ABCDEF);
      wr(`RLC_ADDR_SYNC_HI, 32'h01234567);
      apb(1'b1, `RLC_ADDR_SYNC_HI, 32'hFFFFFFFF, 4'h2);
      chk(packet_sync_word, 64'h0123FF6789ABCDEF);
      rd(`RLC_ADDR_SYNC_LO, 32'h89ABCDEF);
      rd(`RLC_ADDR_SYNC_HI, 32'h0123FF67);
   endtask : sync_word
   task automatic pins_route(input logic tx);
      radio_tx_mode <= tx;
      for (int c = 0; c < 16; c++) begin
         int ix [3];
         logic [2:0] ex;
         logic [2:0] m;
         wr(`RLC_ADDR_PINS, 32'(c) | 32'(c) << 8 | 32'(c % 8) << 16 | 32'(c % 2) * 32'h00404040);
         ix[0] = ck_map[c % 8];
         ix[1] = (tx && (c == 3 || c == 4)) ? 2 * c - 2 : one_map[c];
         ix[2] = c == 2 ? 3 : c == 11 ? 15 : c == 12 ? 17 : ix[1];
         m = {2'b11, ix[0] != 31};
         for (int p = 0; p < 3; p++) begin
            pick <= ix[p] > 25 ? 5'd31 : 5'(ix[p]);
            cycles(5);
            for (int q = 0; q < 3; q++) ex[q] = ((ix[q] == 30) ? tx : (ix[q] == ix[p] && ix[q] < 26)) ^ (c % 2 == 1);
            chk(64'({general_pin_two, general_pin_one, clock_out_pin} & m), 64'(ex & m));
            apb(1'b0, `RLC_ADDR_PINS, 32'h00000000, 4'h0);
            chk(64'(r & 32'(m)), 64'(ex & m));
         end
      end
   endtask : pins_route
   // Two ticks are skipped after each change, since the old count may end early.
   task automatic rate_div;
      int n;
      int k;
      for (int d = 0; d < 8; d += 3) begin
         wr(`RLC_ADDR_RATE, 32'(d));
         rd(`RLC_ADDR_RATE, 32'(d));
         k = 0;
         repeat (2) do @(posedge clock); while (data_rate_tick !== 1'b1 && ++k < 1200);
         n = 0;
         do begin
            @(posedge clock);
            n += int'(master_rate_clock);
         end while (data_rate_tick !== 1'b1 && ++k < 1200);
         chk(64'(n), 64'(d + 1));
      end
   endtask : rate_div
   task automatic fifo_rx;
      radio_tx_mode <= 1'b0;
      wr(`RLC_ADDR_FIFO, 32'h40000005);
      chk(64'(tx_frame_length), 64'h05);
      rx_push <= 1'b1;
      for (int i = 0; i < 64; i++) begin
         rx_push_data <= 8'(i) ^ 8'hA5;
         @(posedge clock);
      end
      rx_push <= 1'b0;
      rx_frame_end <= 1'b1;
      @(posedge clock);
      rx_frame_end <= 1'b0;
      rx_push <= 1'b1;
      @(posedge clock);
      rx_push <= 1'b0;
      cycles(3);
      chk(64'(rx_level), 64'h40);
      rd(`RLC_ADDR_FIFO, 32'h40000040);
      for (int i = 0; i < 13; i++) begin
         rx_pop <= 1'b1;
         @(posedge clock);
         rx_pop <= 1'b0;
         cycles(3);
         chk(64'(rx_pop_data), 64'(8'(i) ^ 8'hA5));
         chk(64'(fifo_pointer_flag), 64'(i < 12));
      end
   endtask : fifo_rx
   task automatic push_tx(input rlc_byte_type d);
      tx_push <= 1'b1;
      tx_push_data <= d;
      @(posedge clock);
      tx_push <= 1'b0;
      @(posedge clock);
   endtask : push_tx
   task automatic pop_tx(input rlc_byte_type exp);
      tx_pop <= 1'b1;
      @(posedge clock);
      tx_pop <= 1'b0;
      cycles(2);
      chk(64'(tx_pop_data), 64'(exp));
   endtask : pop_tx
   task automatic fifo_tx;
      radio_tx_mode <= 1'b1;
      for (int i = 0; i < 3; i++) push_tx(8'h30 + 8'(i));
      tx_frame_start <= 1'b1;
      @(posedge clock);
      tx_frame_start <= 1'b0;
      cycles(2);
      chk(64'(tx_remaining), 64'h05);
      chk(64'(fifo_pointer_flag), 64'h1);
      for (int i = 0; i < 4; i++) pop_tx(8'h30 + 8'(i < 3 ? i : 2));
      chk(64'(tx_remaining), 64'h02);
      for (int i = 3; i < 6; i++) push_tx(8'h30 + 8'(i));
      for (int i = 3; i < 6; i++) pop_tx(8'h30 + 8'(i < 5 ? i : 4));
      chk({tx_level, tx_remaining}, {7'h01, 8'h00});
   endtask : fifo_tx
   ////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {tx_push, tx_push_data, tx_frame_start, tx_pop, rx_push, rx_push_data, rx_frame_end, rx_pop} = '0;
      radio_tx_mode = 1'b0;
      pick = 5'd31;
      fail_count = 0;
      num_checks = 0;
      cycles(2);
      rst_n <= 1'b1;
      @(posedge clock);
      reset_values();
      sync_word();
      pins_route(1'b1);
      pins_route(1'b0);
      rate_div();
      fifo_rx();
      fifo_tx();
      give_verdict();
   end
   initial begin
      cycles(20000);
      fail_count++;
      give_verdict();
   end
endmodule : test_rlc_top
